// ===== pkg/epid_pkg.sv
// package for the external pin interrupt detector: map, fields, resets
package epid_pkg;

    // ************************************************************
    // register map (word addresses on the avalon slave)
    // ************************************************************
    localparam int unsigned        ADDR_W        = 4;          // word address width
    localparam logic [ADDR_W-1:0]  STATCTL_OFS   = 4'h0;       // status and control
    localparam logic [ADDR_W-1:0]  EVT_STAT_OFS  = 4'h1;       // sticky event status
    localparam logic [ADDR_W-1:0]  EVT_MASK_OFS  = 4'h2;       // event mask

    // ************************************************************
    // status and control field positions
    // ************************************************************
    localparam int unsigned BIT_MODE   = 0;   // detection_mode_select
    localparam int unsigned BIT_IE     = 1;   // request_interrupt_enable
    localparam int unsigned BIT_ACK    = 2;   // flag_acknowledge, write only
    localparam int unsigned BIT_FLAG   = 3;   // request_flag, read only
    localparam int unsigned BIT_PFE    = 4;   // pin_function_enable
    localparam int unsigned BIT_POL    = 5;   // polarity_select
    localparam int unsigned BIT_PDD    = 6;   // pull disable, storage only
    localparam int unsigned BIT_RSVD   = 7;   // reserved, reads zero

    // ************************************************************
    // event status / mask field positions
    // ************************************************************
    localparam int unsigned EVT_W        = 2;  // number of event bits
    localparam int unsigned EVT_FLAG_SET = 0;  // request flag went 0 to 1
    localparam int unsigned EVT_IRQ_RISE = 1;  // cpu request asserted

    // ************************************************************
    // reset values
    // ************************************************************
    localparam logic [7:0]       STATCTL_RST = 8'h00;
    localparam logic [EVT_W-1:0] EVT_RST     = 2'h0;
    localparam logic [1:0]       SYNC_RST    = 2'h0;

    // control fields held in flip-flops
    typedef struct packed {
        logic pull_disable;               // no effect on logic here
        logic polarity_select;            // 0 falling/low, 1 rising/high
        logic pin_function_enable;        // pin acts as request input
        logic request_interrupt_enable;   // flag drives cpu request
        logic detection_mode_select;      // 0 edge, 1 edge and level
    } epid_ctrl_t;

    // bus slave states, one-hot
    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,   // waiting for a request
        BUS_ACK  = 2'b10    // answer cycle, waitrequest low
    } epid_bus_state_t;

endpackage : epid_pkg

// ===== rtl/epid_pin_sync.sv
// two-stage synchroniser and polarity-aware edge/level detector
`timescale 1ns/1ps
module epid_pin_sync
    import epid_pkg::*;
(
    // clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // pin and configuration
    input  wire logic pin_in,
    input  wire logic polarity_select,
    // detector outputs
    output logic      asserted_edge,    // one-cycle pulse
    output logic      asserted_level    // synchronised asserted level
);

    // ************************************************************
    // synchroniser
    // ************************************************************
    logic [1:0] sync_reg;      // [0] meta stage, [1] stable stage
    logic [1:0] sync_next;
    logic       prev_reg;      // last stable sample, edge history
    logic       prev_next;
    logic       lvl;

    // next state: first stage feeds only the second stage
    always_comb begin
        sync_next = {sync_reg[0], pin_in};
        prev_next = sync_reg[1];
    end

    // registers
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sync_reg <= SYNC_RST;
            prev_reg <= 1'b0;
        end else begin
            sync_reg <= sync_next;
            prev_reg <= prev_next;
        end
    end

    // ************************************************************
    // detection on the synchronised value only
    // ************************************************************
    // asserted means high when polarity is 1, low when 0
    always_comb begin
        lvl            = ~(sync_reg[1] ^ polarity_select);
        asserted_level = lvl;
        // edge: last sample de-asserted, this one asserted
        asserted_edge  = lvl & (prev_reg ^ polarity_select);
    end

endmodule : epid_pin_sync

// ===== rtl/epid_detector.sv
// external pin interrupt detector top with avalon-mm register slave
// ****************************************************************
// Summary of operation
// - pin enable bit gates request detection
// - bit 3 flag reads pending request
// - writing one to bit 2 clears flag
// - writing zero to acknowledge does nothing
// - acknowledge bit always reads zero
// - level mode: flag held while pin asserted
// - cpu request equals flag and enable bit
// - mode zero detects selected edges only
// - mode one detects edges and levels
// - polarity zero falling/low, one rising/high
// - level mode sets flag on assertion edge
// - reserved bit 7 always reads zero
// ****************************************************************
`timescale 1ns/1ps
module epid_detector
    import epid_pkg::*;
(
    // clock and reset
    input  wire logic              clk,
    input  wire logic              rst,
    // avalon-mm slave
    input  wire logic [ADDR_W-1:0] avs_address,
    input  wire logic              avs_read,
    input  wire logic              avs_write,
    input  wire logic [31:0]       avs_writedata,
    input  wire logic [3:0]        avs_byteenable,
    output logic [31:0]            avs_readdata,
    output logic                   avs_waitrequest,
    // external request pin
    input  wire logic              ext_pin,
    // cpu side
    output logic                   cpu_irq,       // documented request
    output logic                   evt_irq        // masked event summary
);

    // ************************************************************
    // state declarations
    // ************************************************************
    epid_ctrl_t        ctrl_reg;        // writable control fields
    epid_ctrl_t        ctrl_next;
    logic              flag_reg;        // request_flag
    logic              flag_next;
    logic [EVT_W-1:0]  evt_stat_reg;    // sticky event bits
    logic [EVT_W-1:0]  evt_stat_next;
    logic [EVT_W-1:0]  evt_mask_reg;    // event enables
    logic [EVT_W-1:0]  evt_mask_next;
    epid_bus_state_t   bus_reg;         // slave handshake state
    epid_bus_state_t   bus_next;
    logic [31:0]       rdata_reg;       // read data held for answer
    logic [31:0]       rdata_next;
    logic              cpu_irq_reg;     // registered cpu request
    logic              cpu_irq_next;
    logic              evt_irq_reg;     // registered event interrupt
    logic              evt_irq_next;

    // detector wires
    logic              pin_edge;
    logic              pin_level;
    logic              wr_take;         // write takes effect this edge
    logic              lane0;           // low byte lane enabled
    logic              detect;
    logic              ack_hit;
    logic [EVT_W-1:0]  evt_set;

    // ************************************************************
    // functions
    // ************************************************************
    // pack the status and control byte as software sees it
    function automatic logic [7:0] pack_sc(input epid_ctrl_t c,
                                           input logic f);
        logic [7:0] v;
        v           = 8'h00;
        v[BIT_RSVD] = 1'b0;
        v[BIT_PDD]  = c.pull_disable;
        v[BIT_POL]  = c.polarity_select;
        v[BIT_PFE]  = c.pin_function_enable;
        v[BIT_FLAG] = f;
        v[BIT_ACK]  = 1'b0;
        v[BIT_IE]   = c.request_interrupt_enable;
        v[BIT_MODE] = c.detection_mode_select;
        return v;
    endfunction : pack_sc

    // sticky update: set wins over write-one-to-clear
    // clr counts only while wr is high; a bit both set and cleared stays
    function automatic logic [EVT_W-1:0] w1c(input logic [EVT_W-1:0] cur,
                                             input logic [EVT_W-1:0] set,
                                             input logic             wr,
                                             input logic [EVT_W-1:0] clr);
        return (cur & ~(wr ? clr : {EVT_W{1'b0}})) | set;
    endfunction : w1c

    // a write hits a register only with the low byte lane enabled
    function automatic logic wr_sel(input logic              take,
                                    input logic              lane,
                                    input logic [ADDR_W-1:0] addr,
                                    input logic [ADDR_W-1:0] ofs);
        return take && lane && (addr == ofs);
    endfunction : wr_sel

    // ************************************************************
    // pin synchroniser and edge detector
    // ************************************************************
    // pin sampled twice before any edge logic sees it; the detector
    // follows the live polarity bit
    epid_pin_sync u_sync (
        .clk             (clk),
        .rst             (rst),
        .pin_in          (ext_pin),
        .polarity_select (ctrl_reg.polarity_select),
        .asserted_edge   (pin_edge),
        .asserted_level  (pin_level)
    );

    // ************************************************************
    // avalon slave handshake
    // ************************************************************
    // one wait cycle: request seen in idle, answered in ack state.
    // costs a cycle per access but keeps readdata from a flop.
    always_comb begin
        bus_next = bus_reg;
        wr_take  = 1'b0;
        case (bus_reg)
            BUS_IDLE: begin
                // a request raised here is answered one cycle later
                if (avs_read || avs_write) begin
                    bus_next = BUS_ACK;
                end
            end
            BUS_ACK: begin
                // waitrequest is low here, master samples this edge
                wr_take  = avs_write;
                // read data was captured on the request edge
                bus_next = BUS_IDLE;
            end
            default: begin
                // illegal one-hot code: back to idle
                bus_next = BUS_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            bus_reg <= BUS_IDLE;
        end else begin
            bus_reg <= bus_next;
        end
    end

    // ************************************************************
    // control register and request flag
    // ************************************************************
    always_comb begin
        lane0     = avs_byteenable[0];
        ctrl_next = ctrl_reg;
        ack_hit   = 1'b0;
        // writes to the control byte
        if (wr_sel(wr_take, lane0, avs_address, STATCTL_OFS)) begin
            ctrl_next.pull_disable             = avs_writedata[BIT_PDD];
            ctrl_next.polarity_select          = avs_writedata[BIT_POL];
            ctrl_next.pin_function_enable      = avs_writedata[BIT_PFE];
            ctrl_next.request_interrupt_enable = avs_writedata[BIT_IE];
            ctrl_next.detection_mode_select    = avs_writedata[BIT_MODE];
            // only a one acknowledges; a zero is ignored
            ack_hit = avs_writedata[BIT_ACK];
        end
        // detection: disabled pin sees nothing. detect reads the
        // control flops, so a write that enables the pin only starts
        // detection on the edge after it lands
        if (!ctrl_reg.pin_function_enable) begin
            detect = 1'b0;
        end else if (ctrl_reg.detection_mode_select) begin
            detect = pin_edge | pin_level;
        end else begin
            detect = pin_edge;
        end
        // set wins over acknowledge, so a held level keeps the flag
        if (detect) begin
            flag_next = 1'b1;
        end else if (ack_hit) begin
            flag_next = 1'b0;
        end else begin
            flag_next = flag_reg;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctrl_reg <= epid_ctrl_t'(STATCTL_RST[4:0]);
            flag_reg <= STATCTL_RST[BIT_FLAG];
        end else begin
            ctrl_reg <= ctrl_next;
            flag_reg <= flag_next;
        end
    end

    // ************************************************************
    // event status and mask
    // ************************************************************
    // both sticky bits watch the next values, so an event is seen in
    // the same cycle that the flag or the request is loaded
    always_comb begin
        evt_set               = '0;
        evt_set[EVT_FLAG_SET] = flag_next & ~flag_reg;
        evt_set[EVT_IRQ_RISE] = cpu_irq_next & ~cpu_irq_reg;
        // set wins over a clearing write in the same cycle
        evt_stat_next = w1c(evt_stat_reg, evt_set,
                            wr_sel(wr_take, lane0, avs_address,
                                   EVT_STAT_OFS),
                            avs_writedata[EVT_W-1:0]);
        evt_mask_next = evt_mask_reg;
        if (wr_sel(wr_take, lane0, avs_address, EVT_MASK_OFS)) begin
            evt_mask_next = avs_writedata[EVT_W-1:0];
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            evt_stat_reg <= EVT_RST;
            evt_mask_reg <= EVT_RST;
        end else begin
            evt_stat_reg <= evt_stat_next;
            evt_mask_reg <= evt_mask_next;
        end
    end

    // ************************************************************
    // interrupt outputs
    // ************************************************************
    // kept apart from the event logic, which reads cpu_irq_next: a
    // value made later in the same process would be seen stale there.
    // request flop loads on the same edge as the flag behind it
    always_comb begin
        // cpu request follows flag gated by enable
        cpu_irq_next = flag_next
                       & ctrl_next.request_interrupt_enable;
        // summary request: any unmasked sticky event
        evt_irq_next = |(evt_stat_next & evt_mask_next);
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cpu_irq_reg <= 1'b0;
            evt_irq_reg <= 1'b0;
        end else begin
            cpu_irq_reg <= cpu_irq_next;
            evt_irq_reg <= evt_irq_next;
        end
    end

    // ************************************************************
    // read data
    // ************************************************************
    // captured on the request edge in idle, stands through ack cycle
    // so a flag read shows its value from the request edge
    always_comb begin
        rdata_next = rdata_reg;
        if (bus_reg == BUS_IDLE && avs_read) begin
            case (avs_address)
                STATCTL_OFS: begin
                    // live flag; acknowledge and reserved forced to zero
                    rdata_next = {24'h000000, pack_sc(ctrl_reg, flag_reg)};
                end
                EVT_STAT_OFS: begin
                    // bit 0 flag rose, bit 1 cpu request rose
                    rdata_next = {{(32-EVT_W){1'b0}}, evt_stat_reg};
                end
                EVT_MASK_OFS: begin
                    // event enables, same layout as the status
                    rdata_next = {{(32-EVT_W){1'b0}}, evt_mask_reg};
                end
                default: begin
                    // unmapped addresses read zero
                    rdata_next = 32'h00000000;
                end
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdata_reg <= 32'h00000000;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    // ************************************************************
    // outputs, all from flops
    // ************************************************************
    always_comb begin
        avs_readdata    = rdata_reg;
        // high in every state but the answer cycle, reset included
        avs_waitrequest = (bus_reg != BUS_ACK);
        cpu_irq         = cpu_irq_reg;
        evt_irq         = evt_irq_reg;
    end

endmodule : epid_detector

// ===== tb/epid_detector_checker.sv
// port-level assertions for the pin interrupt detector
`timescale 1ns/1ps
module epid_detector_checker
    import epid_pkg::*;
(
    // clock and reset
    input wire logic              clk,
    input wire logic              rst,
    // avalon-mm slave
    input wire logic [ADDR_W-1:0] avs_address,
    input wire logic              avs_read,
    input wire logic              avs_write,
    input wire logic [31:0]       avs_writedata,
    input wire logic [3:0]        avs_byteenable,
    input wire logic [31:0]       avs_readdata,
    input wire logic              avs_waitrequest,
    // pin and requests
    input wire logic              ext_pin,
    input wire logic              cpu_irq,
    input wire logic              evt_irq
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // answer cycles; a write counts only with byte lane 0 on
    logic rd_ack;
    logic wr_ack;
    assign rd_ack = avs_read && !avs_waitrequest;
    assign wr_ack = avs_write && !avs_waitrequest && avs_byteenable[0];

    // ******
    // bus handshake
    // ******
    a_wait_single: assert property ($fell(avs_waitrequest) |=> avs_waitrequest)
        else $error("waitrequest low longer than one cycle");
    a_wait_answer: assert property
        ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("request not answered after one wait cycle");
    a_rdata_hold: assert property (!avs_read |=> $stable(avs_readdata))
        else $error("readdata changed without a read");
    a_unmapped_zero: assert property
        (rd_ack && avs_address > EVT_MASK_OFS |-> avs_readdata == 32'h0)
        else $error("unmapped read not zero");

    // ******
    // register fields and requests
    // ******
    a_ack_reads_zero: assert property (rd_ack && avs_address == STATCTL_OFS
        |-> !avs_readdata[BIT_ACK])
        else $error("acknowledge bit read back as one");
    a_rsvd_reads_zero: assert property (rd_ack && avs_address == STATCTL_OFS
        |-> avs_readdata[31:7] == 25'h0)
        else $error("reserved bits read back nonzero");
    a_irq_needs_enable: assert property (wr_ack && avs_address == STATCTL_OFS
        && !avs_writedata[BIT_IE] |-> ##2 !cpu_irq)
        else $error("cpu request with enable cleared");
    a_mask_off_quiet: assert property (wr_ack && avs_address == EVT_MASK_OFS
        && avs_writedata[1:0] == 2'h0 |-> ##2 !evt_irq)
        else $error("event request with mask cleared");

    // main scenarios reached
    c_read: cover property (rd_ack);
    c_cpu_irq: cover property ($rose(cpu_irq));
    c_evt_irq: cover property ($rose(evt_irq));
endmodule : epid_detector_checker

// ===== tb/epid_pin_src.sv
// behavioural external source driving the request pin
`timescale 1ns/1ps
module epid_pin_src
(
    // clock and requested level
    input  wire logic clk,
    input  wire logic level,
    // driven pin, never released
    output logic      ext_pin
);
    // idles high so a low-asserted pin starts quiet
    initial ext_pin = 1'b1;
    // level moves just after an edge, like a real synchronous source
    always @(posedge clk) begin
        ext_pin <= level;
    end
endmodule : epid_pin_src

// ===== tb/test_epid_detector.sv
// self-checking bench for the pin interrupt detector
`timescale 1ns/1ps
module test_epid_detector
    import epid_pkg::*;
;
    logic              clk, rst, pin_level;
    logic [ADDR_W-1:0] avs_address;
    logic              avs_read, avs_write, avs_waitrequest;
    logic [31:0]       avs_writedata, avs_readdata;
    logic [3:0]        avs_byteenable;
    logic              ext_pin, cpu_irq, evt_irq;
    int                err_total, n_checks, cyc;

    epid_detector DUT (.clk(clk), .rst(rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .ext_pin(ext_pin), .cpu_irq(cpu_irq), .evt_irq(evt_irq));
    epid_pin_src u_src (.clk(clk), .level(pin_level), .ext_pin(ext_pin));

    // 50 ns period
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // ******
    // reporting
    // ******
    task automatic finish_test;
        $display("checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : finish_test

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // hang guard, run needs well under a thousand cycles
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            err_total++;
            finish_test();
        end
    end

    // ******
    // avalon master: one idle edge between accesses
    // ******
    task automatic bus_wr(input logic [ADDR_W-1:0] a, input logic [7:0] d,
                          input logic [3:0] be = 4'h1);
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= {24'h0, d};
        avs_byteenable <= be;
        avs_write <= 1'b1;
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        avs_write <= 1'b0;
    endtask : bus_wr

    task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [7:0] e);
        @(posedge clk);
        avs_address <= a;
        avs_read <= 1'b1;
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        chk("readdata", {24'h0, e}, avs_readdata);
        avs_read <= 1'b0;
    endtask : rd_chk

    // pin move, then room for sync, flag and request
    task automatic pin(input logic v);
        @(posedge clk);
        pin_level <= v;
        repeat (6) @(posedge clk);
    endtask : pin

    task automatic irq_chk(input logic ec, input logic ee);
        repeat (3) @(posedge clk);
        chk("cpu_irq", {31'h0, ec}, {31'h0, cpu_irq});
        chk("evt_irq", {31'h0, ee}, {31'h0, evt_irq});
    endtask : irq_chk

    // ******
    // main sequence
    // ******
    initial begin
        rst = 1'b1;
        pin_level = 1'b1;
        avs_address = '0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = '0;
        avs_byteenable = 4'h1;
        err_total = 0;
        n_checks = 0;
        cyc = 0;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        rd_chk(STATCTL_OFS, 8'h00);
        rd_chk(EVT_STAT_OFS, 8'h00);
        rd_chk(EVT_MASK_OFS, 8'h00);
        bus_wr(STATCTL_OFS, 8'hc0);
        rd_chk(STATCTL_OFS, 8'h40);
        pin(1'b0);
        pin(1'b1);
        rd_chk(STATCTL_OFS, 8'h40);
        bus_wr(STATCTL_OFS, 8'h14);
        rd_chk(STATCTL_OFS, 8'h10);
        pin(1'b0);
        rd_chk(STATCTL_OFS, 8'h18);
        irq_chk(1'b0, 1'b0);
        bus_wr(STATCTL_OFS, 8'h10);
        rd_chk(STATCTL_OFS, 8'h18);
        bus_wr(STATCTL_OFS, 8'h14);
        rd_chk(STATCTL_OFS, 8'h10);
        bus_wr(STATCTL_OFS, 8'h12);
        pin(1'b1);
        pin(1'b0);
        irq_chk(1'b1, 1'b0);
        rd_chk(STATCTL_OFS, 8'h1a);
        bus_wr(STATCTL_OFS, 8'h16);
        irq_chk(1'b0, 1'b0);
        rd_chk(STATCTL_OFS, 8'h12);
        bus_wr(STATCTL_OFS, 8'h13);
        irq_chk(1'b1, 1'b0);
        rd_chk(STATCTL_OFS, 8'h1b);
        bus_wr(STATCTL_OFS, 8'h17);
        rd_chk(STATCTL_OFS, 8'h1b);
        pin(1'b1);
        bus_wr(STATCTL_OFS, 8'h17);
        rd_chk(STATCTL_OFS, 8'h13);
        pin(1'b0);
        rd_chk(STATCTL_OFS, 8'h1b);
        pin(1'b1);
        bus_wr(STATCTL_OFS, 8'h17);
        irq_chk(1'b0, 1'b0);
        // both samples use the live polarity, so the swap fakes no edge; flag acknowledged twice
        bus_wr(STATCTL_OFS, 8'h34);
        irq_chk(1'b0, 1'b0);
        bus_wr(STATCTL_OFS, 8'h34);
        rd_chk(STATCTL_OFS, 8'h30);
        pin(1'b0);
        rd_chk(STATCTL_OFS, 8'h30);
        pin(1'b1);
        rd_chk(STATCTL_OFS, 8'h38);
        bus_wr(STATCTL_OFS, 8'h34);
        rd_chk(STATCTL_OFS, 8'h30);
        // sticky events, mask and summary request
        rd_chk(EVT_STAT_OFS, 8'h03);
        bus_wr(EVT_MASK_OFS, 8'h03);
        irq_chk(1'b0, 1'b1);
        rd_chk(EVT_MASK_OFS, 8'h03);
        bus_wr(EVT_MASK_OFS, 8'h00);
        irq_chk(1'b0, 1'b0);
        bus_wr(EVT_STAT_OFS, 8'h01);
        rd_chk(EVT_STAT_OFS, 8'h02);
        bus_wr(EVT_STAT_OFS, 8'h02);
        rd_chk(EVT_STAT_OFS, 8'h00);
        bus_wr(EVT_MASK_OFS, 8'h01);
        pin(1'b0);
        pin(1'b1);
        irq_chk(1'b0, 1'b1);
        rd_chk(EVT_STAT_OFS, 8'h01);
        bus_wr(EVT_STAT_OFS, 8'h01);
        irq_chk(1'b0, 1'b0);
        // unmapped place and disabled byte lane
        bus_wr(4'hf, 8'hff);
        rd_chk(4'hf, 8'h00);
        bus_wr(STATCTL_OFS, 8'hff, 4'h0);
        rd_chk(STATCTL_OFS, 8'h38);
        // second reset in mid-run
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rd_chk(STATCTL_OFS, 8'h00);
        finish_test();
    end
endmodule : test_epid_detector

bind epid_detector epid_detector_checker u_chk (.clk(clk), .rst(rst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .ext_pin(ext_pin), .cpu_irq(cpu_irq), .evt_irq(evt_irq));
